// *** core/iprio_pkg.sv ***
// Package: register map, field layout and types for the interrupt priority bank
// Behaviour
// - Field code 111 means priority level 7, the highest.
// - Code 001 means level 1; codes between map linearly to levels.
// - Code 000 disables the source; it never raises a request.
// - Bits outside priority fields read zero and hold no state.
// - Every field resets to 100, priority 4.
// - Register 0: adc done bits 6-4, uart1 tx bits 2-0.
// - Register 1: change 14-12, comparator 10-8, i2c1 master 6-4, slave 2-0.
// - Register 2: capture8 14-12, capture7 10-8, extint1 2-0.
// - Register 3: timer4 14-12, compare4 10-8, compare3 6-4.
// - Register 4: uart2 tx 14-12, uart2 rx 10-8, extint2 6-4, timer5 2-0.
// - Register 5: spi2 event 6-4, spi2 fault 2-0.
// - Register 6: capture5 14-12, capture4 10-8, capture3 6-4.
// - Register 7: compare7 14-12, compare6 10-8, compare5 6-4, capture6 2-0.
package iprio_pkg;

    localparam int NREGS = 8;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [2:0] PRIO_MAX = 3'h7;

    // Byte offsets on the register bus
    localparam logic [7:0] OFF_ADC_UART1_TX = 8'h00;
    localparam logic [7:0] OFF_CHANGE_COMPARATOR_I2C1 = 8'h04;
    localparam logic [7:0] OFF_CAPTURE8_7_EXTINT1 = 8'h08;
    localparam logic [7:0] OFF_TIMER4_COMPARE4_3 = 8'h0c;
    localparam logic [7:0] OFF_UART2_EXTINT2_TIMER5 = 8'h10;
    localparam logic [7:0] OFF_SPI2_EVENT_FAULT = 8'h14;
    localparam logic [7:0] OFF_CAPTURE5_4_3 = 8'h18;
    localparam logic [7:0] OFF_COMPARE7_6_5_CAPTURE6 = 8'h1c;

    // Field low-bit positions, shared by all registers
    localparam int POS_F3 = 12;
    localparam int POS_F2 = 8;
    localparam int POS_F1 = 4;
    localparam int POS_F0 = 0;

    // Implemented-bit masks per register
    localparam logic [15:0] MASK_ADC_UART1_TX = 16'h0077;
    localparam logic [15:0] MASK_CHANGE_COMPARATOR_I2C1 = 16'h7777;
    localparam logic [15:0] MASK_CAPTURE8_7_EXTINT1 = 16'h7707;
    localparam logic [15:0] MASK_TIMER4_COMPARE4_3 = 16'h7770;
    localparam logic [15:0] MASK_UART2_EXTINT2_TIMER5 = 16'h7777;
    localparam logic [15:0] MASK_SPI2_EVENT_FAULT = 16'h0077;
    localparam logic [15:0] MASK_CAPTURE5_4_3 = 16'h7770;
    localparam logic [15:0] MASK_COMPARE7_6_5_CAPTURE6 = 16'h7777;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Priority outputs toward the arbiter
    typedef struct packed {
        logic [2:0] adc_done_priority;
        logic [2:0] uart1_tx_priority;
        logic [2:0] change_notify_priority;
        logic [2:0] comparator_priority;
        logic [2:0] i2c1_master_priority;
        logic [2:0] i2c1_slave_priority;
        logic [2:0] capture8_priority;
        logic [2:0] capture7_priority;
        logic [2:0] extint1_priority;
        logic [2:0] timer4_priority;
        logic [2:0] compare4_priority;
        logic [2:0] compare3_priority;
        logic [2:0] uart2_tx_priority;
        logic [2:0] uart2_rx_priority;
        logic [2:0] extint2_priority;
        logic [2:0] timer5_priority;
        logic [2:0] spi2_event_priority;
        logic [2:0] spi2_fault_priority;
        logic [2:0] capture5_priority;
        logic [2:0] capture4_priority;
        logic [2:0] capture3_priority;
        logic [2:0] compare7_priority;
        logic [2:0] compare6_priority;
        logic [2:0] compare5_priority;
        logic [2:0] capture6_priority;
    } iprio_levels_t;

    // Per-source request-enable derived from the field code
    typedef logic [24:0] iprio_enables_t;

endpackage

// *** core/iprio_regs.sv ***
// AXI4-Lite slave holding the eight interrupt priority registers
`timescale 1ns/1ps
module iprio_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output iprio_pkg::iprio_levels_t prio_levels,
    output iprio_pkg::iprio_enables_t source_enable
);

    logic [15:0] regs_q [iprio_pkg::NREGS];
    logic [7:0] awaddr_q;
    logic aw_held_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;
    logic w_held_q;
    logic [15:0] rd_word;
    logic rd_hit;

    // Index of a decoded offset, or -1 when unmapped
    function automatic int reg_index(input logic [7:0] addr);
        if (addr == iprio_pkg::OFF_ADC_UART1_TX) begin
            return 0;
        end else if (addr == iprio_pkg::OFF_CHANGE_COMPARATOR_I2C1) begin
            return 1;
        end else if (addr == iprio_pkg::OFF_CAPTURE8_7_EXTINT1) begin
            return 2;
        end else if (addr == iprio_pkg::OFF_TIMER4_COMPARE4_3) begin
            return 3;
        end else if (addr == iprio_pkg::OFF_UART2_EXTINT2_TIMER5) begin
            return 4;
        end else if (addr == iprio_pkg::OFF_SPI2_EVENT_FAULT) begin
            return 5;
        end else if (addr == iprio_pkg::OFF_CAPTURE5_4_3) begin
            return 6;
        end else if (addr == iprio_pkg::OFF_COMPARE7_6_5_CAPTURE6) begin
            return 7;
        end else begin
            return -1;
        end
    endfunction

    // Implemented-bit mask of a register index
    function automatic logic [15:0] reg_mask(input int idx);
        case (idx)
            0: return iprio_pkg::MASK_ADC_UART1_TX;
            1: return iprio_pkg::MASK_CHANGE_COMPARATOR_I2C1;
            2: return iprio_pkg::MASK_CAPTURE8_7_EXTINT1;
            3: return iprio_pkg::MASK_TIMER4_COMPARE4_3;
            4: return iprio_pkg::MASK_UART2_EXTINT2_TIMER5;
            5: return iprio_pkg::MASK_SPI2_EVENT_FAULT;
            6: return iprio_pkg::MASK_CAPTURE5_4_3;
            7: return iprio_pkg::MASK_COMPARE7_6_5_CAPTURE6;
            default: return 16'h0000;
        endcase
    endfunction

    // Reset pattern: 100 in every implemented field
    function automatic logic [15:0] reg_reset(input int idx);
        logic [15:0] m;
        m = reg_mask(idx);
        return m & {4{1'b0, iprio_pkg::PRIO_RESET}};
    endfunction

    // Extract a 3-bit field from a register word
    function automatic logic [2:0] fld(input logic [15:0] w, input int pos);
        return w[pos +: 3];
    endfunction

    wire logic wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    // Write address capture; address and data may come in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_bvalid;
        end
    end

    // Write data capture; only the low two byte lanes carry state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata[15:0];
            wstrb_q <= s_axi_wstrb[1:0];
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_q && !s_axi_bvalid;
        end
    end

    // Register storage; unimplemented bits are masked so they hold no state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < iprio_pkg::NREGS; i++) begin
                regs_q[i] <= reg_reset(i);
            end
        end else if (wr_fire && reg_index(awaddr_q) >= 0) begin
            for (int i = 0; i < iprio_pkg::NREGS; i++) begin
                if (i == reg_index(awaddr_q)) begin
                    for (int b = 0; b < 2; b++) begin
                        if (wstrb_q[b]) begin
                            regs_q[i][b*8 +: 8] <= 8'((wdata_q & reg_mask(i)) >> (b*8));
                        end
                    end
                end
            end
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= iprio_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (reg_index(awaddr_q) >= 0) ? iprio_pkg::RESP_OKAY
                                                       : iprio_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read decode
    always_comb begin
        rd_word = 16'h0000;
        rd_hit = 1'b0;
        for (int i = 0; i < iprio_pkg::NREGS; i++) begin
            if (i == reg_index(s_axi_araddr)) begin
                rd_word = regs_q[i] & reg_mask(i);
                rd_hit = 1'b1;
            end
        end
    end

    // Read channel; one read in flight, upper half reads zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= iprio_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_word};
            s_axi_rresp <= rd_hit ? iprio_pkg::RESP_OKAY : iprio_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Field export, registered so outputs come from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio_levels <= {25{iprio_pkg::PRIO_RESET}};
        end else begin
            prio_levels.adc_done_priority <= fld(regs_q[0], iprio_pkg::POS_F1);
            prio_levels.uart1_tx_priority <= fld(regs_q[0], iprio_pkg::POS_F0);
            prio_levels.change_notify_priority <= fld(regs_q[1], iprio_pkg::POS_F3);
            prio_levels.comparator_priority <= fld(regs_q[1], iprio_pkg::POS_F2);
            prio_levels.i2c1_master_priority <= fld(regs_q[1], iprio_pkg::POS_F1);
            prio_levels.i2c1_slave_priority <= fld(regs_q[1], iprio_pkg::POS_F0);
            prio_levels.capture8_priority <= fld(regs_q[2], iprio_pkg::POS_F3);
            prio_levels.capture7_priority <= fld(regs_q[2], iprio_pkg::POS_F2);
            prio_levels.extint1_priority <= fld(regs_q[2], iprio_pkg::POS_F0);
            prio_levels.timer4_priority <= fld(regs_q[3], iprio_pkg::POS_F3);
            prio_levels.compare4_priority <= fld(regs_q[3], iprio_pkg::POS_F2);
            prio_levels.compare3_priority <= fld(regs_q[3], iprio_pkg::POS_F1);
            prio_levels.uart2_tx_priority <= fld(regs_q[4], iprio_pkg::POS_F3);
            prio_levels.uart2_rx_priority <= fld(regs_q[4], iprio_pkg::POS_F2);
            prio_levels.extint2_priority <= fld(regs_q[4], iprio_pkg::POS_F1);
            prio_levels.timer5_priority <= fld(regs_q[4], iprio_pkg::POS_F0);
            prio_levels.spi2_event_priority <= fld(regs_q[5], iprio_pkg::POS_F1);
            prio_levels.spi2_fault_priority <= fld(regs_q[5], iprio_pkg::POS_F0);
            prio_levels.capture5_priority <= fld(regs_q[6], iprio_pkg::POS_F3);
            prio_levels.capture4_priority <= fld(regs_q[6], iprio_pkg::POS_F2);
            prio_levels.capture3_priority <= fld(regs_q[6], iprio_pkg::POS_F1);
            prio_levels.compare7_priority <= fld(regs_q[7], iprio_pkg::POS_F3);
            prio_levels.compare6_priority <= fld(regs_q[7], iprio_pkg::POS_F2);
            prio_levels.compare5_priority <= fld(regs_q[7], iprio_pkg::POS_F1);
            prio_levels.capture6_priority <= fld(regs_q[7], iprio_pkg::POS_F0);
        end
    end

    // Enable per source: code 000 masks the request, 001..111 are levels 1..7
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_enable <= '1;
        end else begin
            for (int s = 0; s < 25; s++) begin
                source_enable[s] <= (prio_levels_next(s) != iprio_pkg::PRIO_OFF);
            end
        end
    end

    // Field of source s (struct order, source 0 is the last member)
    function automatic logic [2:0] prio_levels_next(input int s);
        iprio_pkg::iprio_levels_t v;
        v = '{fld(regs_q[0], iprio_pkg::POS_F1), fld(regs_q[0], iprio_pkg::POS_F0),
              fld(regs_q[1], iprio_pkg::POS_F3), fld(regs_q[1], iprio_pkg::POS_F2),
              fld(regs_q[1], iprio_pkg::POS_F1), fld(regs_q[1], iprio_pkg::POS_F0),
              fld(regs_q[2], iprio_pkg::POS_F3), fld(regs_q[2], iprio_pkg::POS_F2),
              fld(regs_q[2], iprio_pkg::POS_F0), fld(regs_q[3], iprio_pkg::POS_F3),
              fld(regs_q[3], iprio_pkg::POS_F2), fld(regs_q[3], iprio_pkg::POS_F1),
              fld(regs_q[4], iprio_pkg::POS_F3), fld(regs_q[4], iprio_pkg::POS_F2),
              fld(regs_q[4], iprio_pkg::POS_F1), fld(regs_q[4], iprio_pkg::POS_F0),
              fld(regs_q[5], iprio_pkg::POS_F1), fld(regs_q[5], iprio_pkg::POS_F0),
              fld(regs_q[6], iprio_pkg::POS_F3), fld(regs_q[6], iprio_pkg::POS_F2),
              fld(regs_q[6], iprio_pkg::POS_F1), fld(regs_q[7], iprio_pkg::POS_F3),
              fld(regs_q[7], iprio_pkg::POS_F2), fld(regs_q[7], iprio_pkg::POS_F1),
              fld(regs_q[7], iprio_pkg::POS_F0)};
        return v[s*3 +: 3]; // level equals the code, 7 highest
    endfunction

endmodule

// *** verification/iprio_regs_chk.sv ***
// Checker for bus timing and arbiter outputs of the priority register bank
`timescale 1ns/1ps
module iprio_regs_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire iprio_pkg::iprio_levels_t prio_levels,
    input wire iprio_pkg::iprio_enables_t source_enable
);
    logic [74:0] lv_bits;
    logic [24:0] nonzero;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Per-source nonzero code, the only thing an enable may depend on
    assign lv_bits = prio_levels;
    always_comb begin
        for (int s = 0; s < 25; s++) begin
            nonzero[s] = |lv_bits[3*s +: 3];
        end
    end
    // Bus answers come within the cycles the handshake logic allows
    a_write_latency: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    a_read_latency: assert property (
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("read answer late");
    a_bresp_held: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_held: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits not zero");
    a_err_data_zero: assert property (
        s_axi_rvalid && s_axi_rresp == iprio_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read carries data");
    a_enable_code: assert property (
        source_enable == nonzero) else $error("enable does not follow code");
    a_levels_cause: assert property (
        $changed(prio_levels) |-> $past(s_axi_bvalid, 1)) else $error("levels changed without write");
    a_reset_defaults: assert property (
        $rose(aresetn) |-> lv_bits == {25{3'h4}} && source_enable == 25'h1ffffff)
        else $error("reset levels wrong");
    a_busy_refuse: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_resp_stall: cover property (s_axi_rvalid && !s_axi_rready);
    c_read_error: cover property (s_axi_rvalid && s_axi_rresp == iprio_pkg::RESP_SLVERR);
    c_source_off: cover property (source_enable != 25'h1ffffff);
endmodule
bind iprio_regs iprio_regs_chk iprio_regs_chk_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .prio_levels(prio_levels), .source_enable(source_enable)
);

// *** verification/iprio_regs_tb.sv ***
// Self-checking bench for the priority register bank over AXI4-Lite
`timescale 1ns/1ps
module iprio_regs_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    iprio_pkg::iprio_levels_t prio_levels;
    iprio_pkg::iprio_enables_t source_enable;
    logic [15:0] exp_q [8];
    logic [31:0] seed = 32'h0000_0062;
    int fails = 0, checks_done = 0;
    localparam logic [15:0] MASKS [8] = '{iprio_pkg::MASK_ADC_UART1_TX,
        iprio_pkg::MASK_CHANGE_COMPARATOR_I2C1, iprio_pkg::MASK_CAPTURE8_7_EXTINT1,
        iprio_pkg::MASK_TIMER4_COMPARE4_3, iprio_pkg::MASK_UART2_EXTINT2_TIMER5,
        iprio_pkg::MASK_SPI2_EVENT_FAULT, iprio_pkg::MASK_CAPTURE5_4_3,
        iprio_pkg::MASK_COMPARE7_6_5_CAPTURE6};
    iprio_regs iprio_regs_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .prio_levels(prio_levels),
        .source_enable(source_enable)
    );
    always #4 aclk = ~aclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Implemented fields packed high to low, register by register
    function automatic logic [74:0] exp_levels();
        logic [74:0] lv;
        int k;
        lv = '0;
        k = 75;
        for (int r = 0; r < 8; r++) begin
            for (int f = 3; f >= 0; f--) begin
                if (MASKS[r][4*f]) begin
                    k -= 3;
                    lv[k +: 3] = exp_q[r][4*f +: 3];
                end
            end
        end
        return lv;
    endfunction
    function automatic logic [24:0] exp_enables(input logic [74:0] lv);
        logic [24:0] en;
        for (int s = 0; s < 25; s++) begin
            en[s] = |lv[3*s +: 3];
        end
        return en;
    endfunction
    task automatic check(input logic [74:0] seen, input logic [74:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("unexpected value at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    // Response ready is held back at random so the slave must stand its answer
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs,
                             input logic [3:0] st = 4'hf);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awprot <= 3'(rnd());
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'(rnd());
        forever begin
            @(posedge aclk);
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (rnd() % 3 == 0) s_axi_bready <= 1'b1;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arprot <= 3'(rnd());
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'(rnd());
        forever begin
            @(posedge aclk);
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (rnd() % 3 == 0) s_axi_rready <= 1'b1;
        end
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Only strobed low lanes change; upper lanes carry no state
    task automatic wr(input int r, input logic [31:0] d, input logic [3:0] st = 4'hf);
        logic [1:0] rs;
        axi_write(8'(4*r), d, rs, st);
        check(rs, iprio_pkg::RESP_OKAY);
        for (int b = 0; b < 2; b++) begin
            if (st[b]) exp_q[r][8*b +: 8] = d[8*b +: 8] & MASKS[r][8*b +: 8];
        end
    endtask
    task automatic verify_all();
        logic [31:0] d;
        logic [1:0] rs;
        for (int r = 0; r < 8; r++) begin
            axi_read(8'(4*r), d, rs);
            check(d, {16'h0000, exp_q[r]});
            check(rs, iprio_pkg::RESP_OKAY);
        end
        check(prio_levels, exp_levels());
        check(source_enable, exp_enables(exp_levels()));
    endtask
    task automatic end_of_test();
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog: generous bound over a run of about a thousand cycles
    initial begin
        repeat (30000) @(posedge aclk);
        fails++;
        end_of_test();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] rs;
        int r;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) exp_q[i] = MASKS[i] & 16'h4444;
        verify_all();
        // Every code in every field, spare bits written as ones
        for (int c = 0; c < 8; c++) begin
            for (int i = 0; i < 8; i++) wr(i, {16'hffff, {4{1'b1, 3'(c)}}});
            verify_all();
        end
        // Random traffic, read back from another random register
        repeat (40) begin
            wr(int'(rnd() % 8), rnd(), 4'(rnd()));
            r = int'(rnd() % 8);
            axi_read(8'(4*r), d, rs);
            check(d, {16'h0000, exp_q[r]});
        end
        // Unmapped places refuse and leave the bank alone
        foreach (MASKS[i]) begin
            axi_write(8'h20 + 8'(i*28), rnd(), rs);
            check(rs, iprio_pkg::RESP_SLVERR);
            axi_read(8'h20 + 8'(i*28), d, rs);
            check(d, 32'h0000_0000);
            check(rs, iprio_pkg::RESP_SLVERR);
        end
        verify_all();
        // Second reset in mid-run restores defaults
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) exp_q[i] = MASKS[i] & 16'h4444;
        verify_all();
        end_of_test();
    end
endmodule
